// ### pkg/psq_pkg.sv
// Constants for the enable-pin power sequencer
package psq_pkg;

    // Register offsets
    localparam logic [7:0] LINREG_A_SEQ_DELAY_OFS = 8'h0e;
    localparam logic [7:0] LINREG_B_SEQ_DELAY_OFS = 8'h0f;
    localparam logic [7:0] GENOUT_A_SEQ_DELAY_OFS = 8'h10;
    localparam logic [7:0] GENOUT_B_SEQ_DELAY_OFS = 8'h11;
    localparam logic [7:0] GENOUT_CONTROL_OFS     = 8'h12;

    // Reset values
    localparam logic [7:0] SEQ_DELAY_RST      = 8'h00;
    localparam logic [7:0] GENOUT_CONTROL_RST = 8'h00;

    // Field positions
    localparam int OFF_CODE_MSB        = 7;
    localparam int OFF_CODE_LSB        = 4;
    localparam int ON_CODE_MSB         = 3;
    localparam int ON_CODE_LSB         = 0;
    localparam int GENOUT_B_DRIVE_POS  = 6;
    localparam int GENOUT_B_GATING_POS = 5;
    localparam int GENOUT_B_LEVEL_POS  = 4;
    localparam int GENOUT_A_DRIVE_POS  = 2;
    localparam int GENOUT_A_GATING_POS = 1;
    localparam int GENOUT_A_LEVEL_POS  = 0;
    localparam logic [7:0] GENOUT_CONTROL_WMASK = 8'h77;

    // Channel numbering
    localparam int CH_LINREG_A = 0;
    localparam int CH_LINREG_B = 1;
    localparam int CH_GENOUT_A = 2;
    localparam int CH_GENOUT_B = 3;
    localparam int NUM_CH      = 4;

    // Time base: one step is half a millisecond
    localparam int CLK_PERIOD_NS  = 40;
    localparam int HALF_MS_NS     = 500000;
    localparam int HALF_MS_CYCLES = HALF_MS_NS / CLK_PERIOD_NS;

    // Elapsed step counter
    localparam int              STEP_W   = 5;
    localparam logic [4:0]      STEP_MAX = 5'h1f;
    localparam int              PRE_W    = 14;

endpackage

// ### logic/psq_sequencer.sv
// Enable-pin sequencer for two linear regulators and two general outputs
// How it works
// - First regulator switches off after falling-edge delay from delay bits 7:4.
// - First regulator switches on after rising-edge delay from delay bits 3:0.
// - Off range select high makes every off delay step 1 ms.
// - On range select high makes every on delay step 1 ms.
// - Second regulator off delay comes from bits 7:4 of its register.
// - Second regulator on delay comes from bits 3:0 of its register.
// - First general output falls after delay code in bits 7:4.
// - First general output rises after delay code in bits 3:0.
// - Second general output falls after delay code in bits 7:4.
// - Second general output rises after delay code in bits 3:0.
// - Control bit 6 picks push-pull or open-drain for second output.
// - Control bit 5 gates second output level with enable pin.
// - Control bit 4 sets second output level.
// - Control bit 2 picks push-pull or open-drain for first output.
// - Control bit 1 gates first output level with enable pin.
// - Control bit 0 sets first output level.
// - Range low means 0.5 ms steps, high means 1 ms steps, linear.
// - Pin function bit selects second output or external clock input.
// - Pin-gated regulator is on only with enable bit and sequenced pin.
`timescale 1ns/1ns
`default_nettype none

module psq_sequencer
    import psq_pkg::*;
#(
    parameter int HALF_MS_CYC = HALF_MS_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       en_pin,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output var  logic [7:0] reg_rdata,
    input  wire logic       on_range_sel,
    input  wire logic       off_range_sel,
    input  wire logic       shared_pin_function,
    input  wire logic       linreg_a_enable_bit,
    input  wire logic       linreg_a_pin_gating,
    input  wire logic       linreg_b_enable_bit,
    input  wire logic       linreg_b_pin_gating,
    output var  logic       linreg_a_en,
    output var  logic       linreg_b_en,
    output var  logic       genout_a_o,
    output var  logic       genout_a_oe,
    output var  logic       genout_b_o,
    output var  logic       genout_b_oe
);

    // Delay code to count of half-ms steps
    function automatic logic [4:0] seq_target(input logic [3:0] code, input logic wide);
        seq_target = wide ? {code, 1'b0} : {1'b0, code};
    endfunction

    logic [7:0]        dly_reg [NUM_CH];
    logic [7:0]        ctl_reg;
    logic              en_meta_reg;
    logic              en_sync_reg;
    logic              en_prev_reg;
    logic              pin_edge;
    logic [PRE_W-1:0]  pre_reg;
    logic [STEP_W-1:0] step_reg;
    logic [STEP_W-1:0] cmp_cnt;
    logic [4:0]        on_tgt  [NUM_CH];
    logic [4:0]        off_tgt [NUM_CH];
    logic [NUM_CH-1:0] seq_reg;
    logic [NUM_CH-1:0] seq_next;
    logic              ga_val;
    logic              gb_val;
    logic [7:0]        rd_next;

    // Enable pin synchroniser
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            en_meta_reg <= 1'b0;
            en_sync_reg <= 1'b0;
            en_prev_reg <= 1'b0;
        end else begin
            en_meta_reg <= en_pin;
            en_sync_reg <= en_meta_reg;
            en_prev_reg <= en_sync_reg;
        end
    end

    assign pin_edge = en_sync_reg ^ en_prev_reg;

    // Half-ms time base, restarted on every pin edge
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pre_reg  <= '0;
            step_reg <= '0;
        end else if (pin_edge) begin
            pre_reg  <= '0;
            step_reg <= '0;
        end else if (pre_reg == PRE_W'(HALF_MS_CYC - 1)) begin
            pre_reg <= '0;
            if (step_reg != STEP_MAX) begin
                step_reg <= step_reg + 5'h01;
            end
        end else begin
            pre_reg <= pre_reg + 14'h0001;
        end
    end

    // Steps elapsed since the newest edge
    assign cmp_cnt = pin_edge ? '0 : step_reg;

    // Per-channel delay targets
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            on_tgt[i]  = seq_target(dly_reg[i][ON_CODE_MSB:ON_CODE_LSB], on_range_sel);
            off_tgt[i] = seq_target(dly_reg[i][OFF_CODE_MSB:OFF_CODE_LSB], off_range_sel);
        end
    end

    // Sequenced level follows the pin direction once its delay has run
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            if (en_sync_reg) begin
                seq_next[i] = seq_reg[i] | (cmp_cnt >= on_tgt[i]);
            end else begin
                seq_next[i] = seq_reg[i] & (cmp_cnt < off_tgt[i]);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            seq_reg <= '0;
        end else begin
            seq_reg <= seq_next;
        end
    end

    // Register writes
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                dly_reg[i] <= SEQ_DELAY_RST;
            end
            ctl_reg <= GENOUT_CONTROL_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                LINREG_A_SEQ_DELAY_OFS: dly_reg[CH_LINREG_A] <= reg_wdata;
                LINREG_B_SEQ_DELAY_OFS: dly_reg[CH_LINREG_B] <= reg_wdata;
                GENOUT_A_SEQ_DELAY_OFS: dly_reg[CH_GENOUT_A] <= reg_wdata;
                GENOUT_B_SEQ_DELAY_OFS: dly_reg[CH_GENOUT_B] <= reg_wdata;
                GENOUT_CONTROL_OFS:     ctl_reg <= reg_wdata & GENOUT_CONTROL_WMASK;
                default:                ;
            endcase
        end
    end

    // Register read data, unmapped reads zero
    always_comb begin
        unique case (reg_addr)
            LINREG_A_SEQ_DELAY_OFS: rd_next = dly_reg[CH_LINREG_A];
            LINREG_B_SEQ_DELAY_OFS: rd_next = dly_reg[CH_LINREG_B];
            GENOUT_A_SEQ_DELAY_OFS: rd_next = dly_reg[CH_GENOUT_A];
            GENOUT_B_SEQ_DELAY_OFS: rd_next = dly_reg[CH_GENOUT_B];
            GENOUT_CONTROL_OFS:     rd_next = ctl_reg & GENOUT_CONTROL_WMASK;
            default:                rd_next = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_next;
        end
    end

    // General output levels, optionally gated by the sequenced pin
    assign ga_val = ctl_reg[GENOUT_A_LEVEL_POS]
                  & (!ctl_reg[GENOUT_A_GATING_POS] | seq_reg[CH_GENOUT_A]);
    assign gb_val = ctl_reg[GENOUT_B_LEVEL_POS]
                  & (!ctl_reg[GENOUT_B_GATING_POS] | seq_reg[CH_GENOUT_B]);

    // Regulator enables
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            linreg_a_en <= 1'b0;
            linreg_b_en <= 1'b0;
        end else begin
            linreg_a_en <= linreg_a_enable_bit & (!linreg_a_pin_gating | seq_reg[CH_LINREG_A]);
            linreg_b_en <= linreg_b_enable_bit & (!linreg_b_pin_gating | seq_reg[CH_LINREG_B]);
        end
    end

    // Pin drivers: open-drain drives only the low level
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            genout_a_o  <= 1'b0;
            genout_a_oe <= 1'b0;
            genout_b_o  <= 1'b0;
            genout_b_oe <= 1'b0;
        end else begin
            genout_a_o  <= ga_val;
            genout_a_oe <= !ctl_reg[GENOUT_A_DRIVE_POS] | !ga_val;
            genout_b_o  <= gb_val;
            genout_b_oe <= !shared_pin_function
                         & (!ctl_reg[GENOUT_B_DRIVE_POS] | !gb_val);
        end
    end

    // Checks
    off_a_a: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(seq_reg[CH_LINREG_A]) |-> $past(cmp_cnt) >= $past(off_tgt[CH_LINREG_A]) && !$past(en_sync_reg))
        else $error("first regulator turned off early");
    on_a_a: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(seq_reg[CH_LINREG_A]) |-> $past(cmp_cnt) >= $past(on_tgt[CH_LINREG_A]) && $past(en_sync_reg))
        else $error("first regulator turned on early");
    off_wide_a: assert property (@(posedge mclk) disable iff (!resetn)
        (off_range_sel && !en_sync_reg && dly_reg[CH_LINREG_B][7:4] == 4'h1 && cmp_cnt == 5'h01)
        |-> seq_next[CH_LINREG_B] == seq_reg[CH_LINREG_B])
        else $error("wide off range acted at half step");
    on_wide_a: assert property (@(posedge mclk) disable iff (!resetn)
        (on_range_sel && en_sync_reg && !seq_reg[CH_LINREG_A] && dly_reg[CH_LINREG_A][3:0] == 4'h1
         && cmp_cnt == 5'h01) |=> !seq_reg[CH_LINREG_A])
        else $error("wide on range acted at half step");
    off_b_a: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(seq_reg[CH_LINREG_B]) |-> $past(cmp_cnt) >= $past(off_tgt[CH_LINREG_B]))
        else $error("second regulator turned off early");
    on_b_a: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(seq_reg[CH_LINREG_B]) |-> $past(cmp_cnt) >= $past(on_tgt[CH_LINREG_B]))
        else $error("second regulator turned on early");
    fall_ga_a: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(seq_reg[CH_GENOUT_A]) |-> $past(cmp_cnt) >= $past(off_tgt[CH_GENOUT_A]))
        else $error("first output fell early");
    rise_ga_a: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(seq_reg[CH_GENOUT_A]) |-> $past(cmp_cnt) >= $past(on_tgt[CH_GENOUT_A]))
        else $error("first output rose early");
    fall_gb_a: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(seq_reg[CH_GENOUT_B]) |-> $past(cmp_cnt) >= $past(off_tgt[CH_GENOUT_B]))
        else $error("second output fell early");
    rise_gb_a: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(seq_reg[CH_GENOUT_B]) |-> $past(cmp_cnt) >= $past(on_tgt[CH_GENOUT_B]))
        else $error("second output rose early");
    clk_pin_a: assert property (@(posedge mclk) disable iff (!resetn)
        shared_pin_function |=> !genout_b_oe)
        else $error("shared pin driven in clock mode");
    od_b_a: assert property (@(posedge mclk) disable iff (!resetn)
        genout_b_oe && genout_b_o |-> !$past(ctl_reg[GENOUT_B_DRIVE_POS]))
        else $error("open-drain second output drove high");
    gate_a_a: assert property (@(posedge mclk) disable iff (!resetn)
        genout_a_o |-> $past(ctl_reg[GENOUT_A_LEVEL_POS]) && $past(seq_reg[CH_GENOUT_A] || !ctl_reg[GENOUT_A_GATING_POS]))
        else $error("first output high without cause");
    step_time_a: assert property (@(posedge mclk) disable iff (!resetn)
        $changed(step_reg) && !$past(pin_edge) |-> $past(pre_reg) == PRE_W'(HALF_MS_CYC - 1))
        else $error("step taken off the half-ms tick");
    rsvd_rd_a: assert property (@(posedge mclk) disable iff (!resetn)
        reg_rd && reg_addr == GENOUT_CONTROL_OFS |=> reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0)
        else $error("reserved control bits read nonzero");
    restart_a: assert property (@(posedge mclk) disable iff (!resetn)
        pin_edge |=> step_reg == '0 && pre_reg == '0)
        else $error("pin edge did not restart timing");

    rise_seq_c: cover property (@(posedge mclk) disable iff (!resetn) $rose(linreg_a_en));
    fall_seq_c: cover property (@(posedge mclk) disable iff (!resetn) $fell(genout_b_o));
    cancel_c: cover property (@(posedge mclk) disable iff (!resetn)
        pin_edge && seq_reg[CH_LINREG_A] != en_prev_reg);
    wide_c: cover property (@(posedge mclk) disable iff (!resetn) on_range_sel && $rose(seq_reg[CH_GENOUT_A]));

endmodule

`default_nettype wire

// ### tb/psq_host_model.sv
// Host-side model that drives the enable pin of the sequencer
`timescale 1ns/1ns
`default_nettype none

module psq_host_model (
    input  wire logic mclk,
    output var  logic en_pin
);
    // Pin starts low; the host raises it only on command
    initial en_pin = 1'b0;

    // Change the level just after a falling edge and hold it until the next command
    task automatic drive(input logic lvl);
        @(negedge mclk);
        en_pin = lvl;
    endtask
endmodule

`default_nettype wire

// ### tb/enable_pin_sequencer_delays_tb_top.sv
// Self-checking bench for the enable-pin sequencer
`timescale 1ns/1ns
`default_nettype none

module enable_pin_sequencer_delays_tb_top;
    import psq_pkg::*;
    localparam int H = 4;
    logic        mclk, resetn, en_pin, reg_wr, reg_rd, on_range_sel, off_range_sel, shared_pin_function;
    logic        linreg_a_enable_bit, linreg_a_pin_gating, linreg_b_enable_bit, linreg_b_pin_gating;
    logic        linreg_a_en, linreg_b_en, genout_a_o, genout_a_oe, genout_b_o, genout_b_oe;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, rdv, dly[4], ctl;
    logic [7:0]  ofs[4] = '{LINREG_A_SEQ_DELAY_OFS, LINREG_B_SEQ_DELAY_OFS, GENOUT_A_SEQ_DELAY_OFS, GENOUT_B_SEQ_DELAY_OFS};
    logic [31:0] seed = 32'hf945a182;
    int          err_count = 0, comparisons = 0, lat[4];
    logic [3:0]  outs;

    psq_sequencer #(.HALF_MS_CYC(H)) u_psq_sequencer (.mclk(mclk), .resetn(resetn), .en_pin(en_pin),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .on_range_sel(on_range_sel), .off_range_sel(off_range_sel), .shared_pin_function(shared_pin_function),
        .linreg_a_enable_bit(linreg_a_enable_bit), .linreg_a_pin_gating(linreg_a_pin_gating),
        .linreg_b_enable_bit(linreg_b_enable_bit), .linreg_b_pin_gating(linreg_b_pin_gating),
        .linreg_a_en(linreg_a_en), .linreg_b_en(linreg_b_en), .genout_a_o(genout_a_o),
        .genout_a_oe(genout_a_oe), .genout_b_o(genout_b_o), .genout_b_oe(genout_b_oe));
    psq_host_model u_psq_host_model (.mclk(mclk), .en_pin(en_pin));

    // Sequenced outputs by channel number
    assign outs = {genout_b_o, genout_a_o, linreg_b_en, linreg_a_en};

    // Clock
    initial mclk = 1'b0;
    always #20 mclk = ~mclk;

    // Xorshift source for codes and register data
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Reference latency in edges, counting the first edge after the pin change as one
    // Two sync edges, restart edge, state edge, output edge; a zero code acts on the restart edge
    function int exp_lat(input int code, input int rng);
        return (code == 0) ? 4 : 5 + (rng != 0 ? 2 * code : code) * H;
    endfunction

    task automatic fail_msg(input string what);
        err_count++;
        $display("[FAIL] %0t %s", $time, what);
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) fail_msg($sformatf("register read %h expected %h", got, exp));
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) fail_msg($sformatf("pin level %b expected %b", got, exp));
    endtask
    task automatic chk_lat(input int got, input int exp);
        comparisons++;
        if (got != exp) fail_msg($sformatf("latency %0d expected %0d", got, exp));
    endtask

    task automatic test_done();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Register port cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask

    // Move the pin and count edges until each sequenced output reaches the new level
    task automatic measure(input logic lvl);
        logic [3:0] seen;
        seen = 4'h0;
        u_psq_host_model.drive(lvl);
        for (int n = 1; n <= 200 && seen != 4'hf; n++) begin
            @(posedge mclk);
            #1;
            for (int i = 0; i < 4; i++) begin
                if (!seen[i] && outs[i] === lvl) begin
                    seen[i] = 1'b1;
                    lat[i] = n;
                end
            end
        end
        if (seen != 4'hf) begin
            fail_msg("sequenced output never switched");
            test_done();
        end
        // Hand back on a falling edge so following stimulus keeps to it
        @(negedge mclk);
    endtask

    initial begin
        {resetn, reg_wr, reg_rd, on_range_sel, off_range_sel, shared_pin_function} = 6'h00;
        {linreg_a_enable_bit, linreg_a_pin_gating, linreg_b_enable_bit, linreg_b_pin_gating} = 4'hf;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (3) @(negedge mclk);
        resetn = 1'b1;
        // Reset values, unmapped place, reserved control bits
        for (int i = 0; i < 4; i++) begin
            rd(ofs[i], rdv);
            chk_reg(rdv, 8'h00);
        end
        wr(8'h13, 8'hff);
        rd(8'h13, rdv);
        chk_reg(rdv, 8'h00);
        wr(GENOUT_CONTROL_OFS, 8'hff);
        rd(GENOUT_CONTROL_OFS, rdv);
        chk_reg(rdv, 8'h77);
        // Gated push-pull outputs at level one, sequenced by the pin
        wr(GENOUT_CONTROL_OFS, 8'h33);
        for (int k = 0; k < 6; k++) begin
            {off_range_sel, on_range_sel} = (k < 4) ? k[1:0] : rnd();
            for (int i = 0; i < 4; i++) begin
                dly[i] = (k == 0) ? 8'hf0 : (k == 1) ? 8'h0f : (k == 3) ? 8'h11 : rnd();
                wr(ofs[i], dly[i]);
                rd(ofs[i], rdv);
                chk_reg(rdv, dly[i]);
            end
            measure(1'b1);
            for (int i = 0; i < 4; i++) chk_lat(lat[i], exp_lat(dly[i][3:0], on_range_sel));
            chk_pin(genout_a_oe & genout_b_oe, 1'b1);
            measure(1'b0);
            for (int i = 0; i < 4; i++) chk_lat(lat[i], exp_lat(dly[i][7:4], off_range_sel));
        end
        // Pin drops again before the long rise delay ends
        for (int i = 0; i < 4; i++) wr(ofs[i], 8'h0f);
        {off_range_sel, on_range_sel} = 2'b00;
        u_psq_host_model.drive(1'b1);
        repeat (20) @(negedge mclk);
        u_psq_host_model.drive(1'b0);
        for (int n = 0; n < 80; n++) begin
            @(negedge mclk);
            if (outs !== 4'h0) fail_msg("cancelled rise still reached an output");
        end
        chk_pin(|outs, 1'b0);
        // Ungated level, drive type and shared pin function table
        linreg_a_pin_gating = 1'b0;
        for (int j = 0; j < 4; j++) begin
            ctl = (j == 0) ? 8'h11 : (j == 1) ? 8'h44 : (j == 2) ? 8'h55 : 8'h00;
            shared_pin_function = (j == 2);
            linreg_a_enable_bit = ctl[0];
            wr(GENOUT_CONTROL_OFS, ctl);
            u_psq_host_model.drive(j[0]);
            repeat (3) @(negedge mclk);
            chk_pin(genout_a_o, ctl[0]);
            chk_pin(genout_b_o, ctl[4]);
            chk_pin(genout_a_oe, ctl[2] ? !ctl[0] : 1'b1);
            chk_pin(genout_b_oe, !shared_pin_function && (ctl[6] ? !ctl[4] : 1'b1));
            chk_pin(linreg_a_en, ctl[0]);
            chk_pin(linreg_b_en, 1'b0);
        end
        test_done();
    end
endmodule

`default_nettype wire
